/* rtl/rcc_pkg.sv */
// Shared constants and types for the operand core
package rcc_pkg;
  localparam logic [3:0]  PC_IDX       = 4'h0;
  localparam logic [3:0]  SP_IDX       = 4'h1;
  localparam logic [3:0]  SR_IDX       = 4'h2;
  localparam logic [3:0]  CG_IDX       = 4'h3;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam int          C_BIT        = 0;
  localparam int          Z_BIT        = 1;
  localparam int          N_BIT        = 2;
  localparam int          V_BIT        = 8;
  localparam logic [1:0]  AM_REG       = 2'h0;
  localparam logic [1:0]  AM_IDX       = 2'h1;
  localparam logic [1:0]  AM_IND       = 2'h2;
  localparam logic [1:0]  AM_INC       = 2'h3;
  localparam logic [4:0]  OP_MOV  = 5'h04, OP_ADD  = 5'h05, OP_ADDC = 5'h06, OP_SUBC = 5'h07;
  localparam logic [4:0]  OP_SUB  = 5'h08, OP_CMP  = 5'h09, OP_DADD = 5'h0a, OP_BIT  = 5'h0b;
  localparam logic [4:0]  OP_BIC  = 5'h0c, OP_BIS  = 5'h0d, OP_XOR  = 5'h0e, OP_AND  = 5'h0f;
  localparam logic [4:0]  OP_RRC  = 5'h10, OP_SWPB = 5'h11, OP_RRA  = 5'h12, OP_SXT  = 5'h13;
  localparam logic [4:0]  OP_PUSH = 5'h14, OP_CALL = 5'h15, OP_RETI = 5'h16;

  typedef enum logic [9:0] {
    S_VEC  = 10'h001,
    S_FET  = 10'h002,
    S_SEXT = 10'h004,
    S_SRD  = 10'h008,
    S_DEXT = 10'h010,
    S_DRD  = 10'h020,
    S_DWR  = 10'h040,
    S_PUSH = 10'h080,
    S_POP1 = 10'h100,
    S_POP2 = 10'h200
  } rcc_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        rd;
    logic        wr;
    logic        narrow;
  } rcc_bus_req_t;

  typedef struct packed {
    logic [15:0] res;
    logic [15:0] sr;
  } rcc_alu_t;

  typedef struct packed {
    rcc_state_t        st;
    logic [15:0][15:0] regs;
    logic [15:0]       ir;
    logic [15:0]       sval;
    logic [15:0]       dadr;
    logic [15:0]       dval;
  } rcc_core_t;
endpackage

/* rtl/rcc_core.sv */
// Instruction execution and operand handling core
`timescale 1ns/1ps
`default_nettype none
module rcc_core (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Shared memory and peripheral bus
  output rcc_pkg::rcc_bus_req_t     bus_req,
  input  wire logic [15:0]          bus_rdata,
  input  wire logic                 bus_ready,
  // State view
  output logic [15:0]               pc_view,
  output logic [15:0]               status_view
);
  import rcc_pkg::*;
  rcc_core_t    q;
  rcc_core_t    next_q;
  rcc_bus_req_t req;
  function automatic logic [15:0] cg_value(input logic [3:0] r, input logic [1:0] as);
    if (r == SR_IDX) cg_value = as[0] ? 16'h0008 : 16'h0004;
    else case (as)
      2'h0:    cg_value = 16'h0000;
      2'h1:    cg_value = 16'h0001;
      2'h2:    cg_value = 16'h0002;
      default: cg_value = 16'hffff;
    endcase
  endfunction
  function automatic logic [15:0] rd_lane(input logic [15:0] d, input logic a0, input logic bw);
    rd_lane = !bw ? d : (a0 ? {8'h00, d[15:8]} : {8'h00, d[7:0]});
  endfunction
  function automatic logic taken(input logic [2:0] c, input logic [15:0] sr);
    case (c)
      3'h0:    taken = !sr[Z_BIT];
      3'h1:    taken = sr[Z_BIT];
      3'h2:    taken = !sr[C_BIT];
      3'h3:    taken = sr[C_BIT];
      3'h4:    taken = sr[N_BIT];
      3'h5:    taken = !(sr[N_BIT] ^ sr[V_BIT]);
      3'h6:    taken = sr[N_BIT] ^ sr[V_BIT];
      default: taken = 1'b1;
    endcase
  endfunction
  function automatic logic writes(input logic [4:0] op);
    writes = (op != OP_CMP) && (op != OP_BIT);
  endfunction
  // Decimal add runs as binary add with carry; no nibble correction
  function automatic rcc_alu_t alu(input logic [4:0] op, input logic [15:0] s, input logic [15:0] d,
                                   input logic [15:0] sr, input logic bw);
    rcc_alu_t    a;
    logic [16:0] sum;
    logic [15:0] m, x, y, addend;
    logic        cin, ms_y, ms_a, ms_r, z;
    m      = bw ? 16'h00ff : 16'hffff;
    x      = s & m;
    y      = d & m;
    addend = ((op == OP_SUBC) || (op == OP_SUB) || (op == OP_CMP)) ? (~x & m) : x;
    cin    = ((op == OP_ADDC) || (op == OP_SUBC) || (op == OP_DADD)) ? sr[C_BIT] : ((op == OP_SUB) || (op == OP_CMP));
    sum    = {1'b0, y} + {1'b0, addend} + {16'h0000, cin};
    a.sr   = sr;
    case (op)
      OP_MOV:                                                  a.res = x;
      OP_ADD, OP_ADDC, OP_SUBC, OP_SUB, OP_CMP, OP_DADD:       a.res = sum[15:0];
      OP_BIT, OP_AND:                                          a.res = x & y;
      OP_BIC:                                                  a.res = y & ~x;
      OP_BIS:                                                  a.res = y | x;
      OP_XOR:                                                  a.res = x ^ y;
      OP_RRC: a.res = (y >> 1) | (bw ? {8'h00, sr[C_BIT], 7'h00} : {sr[C_BIT], 15'h0000});
      OP_RRA: a.res = (y >> 1) | (y & (bw ? 16'h0080 : 16'h8000));
      OP_SWPB:                                                 a.res = {d[7:0], d[15:8]};
      OP_SXT:                                                  a.res = {{8{d[7]}}, d[7:0]};
      default:                                                 a.res = y;
    endcase
    a.res = a.res & m;
    ms_y  = bw ? y[7] : y[15];
    ms_a  = bw ? addend[7] : addend[15];
    ms_r  = bw ? a.res[7] : a.res[15];
    z     = (a.res == 16'h0000);
    case (op)
      OP_ADD, OP_ADDC, OP_SUBC, OP_SUB, OP_CMP, OP_DADD: begin
        a.sr[C_BIT] = bw ? sum[8] : sum[16];
        a.sr[V_BIT] = (ms_y == ms_a) && (ms_r != ms_y);
        a.sr[N_BIT] = ms_r;
        a.sr[Z_BIT] = z;
      end
      OP_BIT, OP_AND, OP_XOR, OP_SXT: begin
        a.sr[C_BIT] = !z;
        a.sr[V_BIT] = (op == OP_XOR) && ms_y && (bw ? x[7] : x[15]);
        a.sr[N_BIT] = ms_r;
        a.sr[Z_BIT] = z;
      end
      OP_RRC, OP_RRA: begin
        a.sr[C_BIT] = y[0];
        a.sr[V_BIT] = 1'b0;
        a.sr[N_BIT] = ms_r;
        a.sr[Z_BIT] = z;
      end
      default: a.sr = sr;
    endcase
    return a;
  endfunction
  always_comb begin
    logic [15:0] i, sv, pc;
    logic [3:0]  sreg, dreg;
    logic [1:0]  as;
    logic [4:0]  op;
    logic        bw, dual, single, jmp, cg, imm, ext_s, mem_s, go;
    rcc_alu_t    a;
    next_q = q;
    req    = '0;
    go     = 1'b0;
    sv     = q.sval;
    a      = '0;
    i      = (q.st == S_FET) ? bus_rdata : q.ir;
    pc     = q.regs[PC_IDX];
    dual   = (i[15:14] != 2'h0);
    single = (i[15:10] == 6'h04) && (i[9:7] != 3'h7);
    jmp    = (i[15:13] == 3'h1);
    sreg   = dual ? i[11:8] : i[3:0];
    dreg   = i[3:0];
    as     = i[5:4];
    bw     = i[6] && !(single && (i[9:7] >= 3'h5));
    op     = dual ? {1'b0, i[15:12]} : {2'h2, i[9:7]};
    cg     = (sreg == CG_IDX) || ((sreg == SR_IDX) && as[1]);
    imm    = (sreg == PC_IDX) && (as == AM_INC);
    ext_s  = ((as == AM_IDX) && (sreg != CG_IDX)) || imm;
    mem_s  = !cg && (as != AM_REG);
    case (q.st)
      S_VEC: begin
        req.rd   = 1'b1;
        req.addr = RESET_VECTOR;
        if (bus_ready) begin
          next_q.regs[PC_IDX] = bus_rdata;
          next_q.st           = S_FET;
        end
      end
      S_FET: begin
        req.rd   = 1'b1;
        req.addr = pc;
        if (bus_ready) begin
          next_q.ir           = bus_rdata;
          next_q.regs[PC_IDX] = pc + 16'h0002;
          if (jmp) begin
            if (taken(i[12:10], q.regs[SR_IDX]))
              next_q.regs[PC_IDX] = pc + 16'h0002 + {{5{i[9]}}, i[9:0], 1'b0};
          end else if (dual || single) begin
            if (ext_s) next_q.st = S_SEXT;
            else if (mem_s) begin
              next_q.dadr = q.regs[sreg];
              next_q.st   = S_SRD;
            end else begin
              // Register or constant source: taken in this same cycle; ops with a register destination also execute here
              sv = cg ? cg_value(sreg, as) : ((sreg == PC_IDX) ? pc + 16'h0002 : q.regs[sreg]);
              go = 1'b1;
            end
          end
        end
      end
      S_SEXT: begin
        req.rd   = 1'b1;
        req.addr = pc;
        if (bus_ready) begin
          next_q.regs[PC_IDX] = pc + 16'h0002;
          if (imm) begin
            sv = bus_rdata;
            go = 1'b1;
          end else begin
            next_q.dadr = bus_rdata + ((sreg == SR_IDX) ? 16'h0000 : q.regs[sreg]);
            next_q.st   = S_SRD;
          end
        end
      end
      S_SRD: begin
        req.rd     = 1'b1;
        req.addr   = q.dadr;
        req.narrow = bw;
        if (bus_ready) begin
          sv = rd_lane(bus_rdata, q.dadr[0], bw);
          if (as == AM_INC) next_q.regs[sreg] = q.regs[sreg] + (bw ? 16'h0001 : 16'h0002);
          go = 1'b1;
        end
      end
      S_DEXT: begin
        req.rd   = 1'b1;
        req.addr = pc;
        if (bus_ready) begin
          next_q.regs[PC_IDX] = pc + 16'h0002;
          next_q.dadr = bus_rdata + ((dreg == SR_IDX) ? 16'h0000 : q.regs[dreg]);
          next_q.dval = q.sval;
          // Move needs no read of the old destination
          next_q.st   = (op == OP_MOV) ? S_DWR : S_DRD;
        end
      end
      S_DRD: begin
        req.rd     = 1'b1;
        req.addr   = q.dadr;
        req.narrow = bw;
        if (bus_ready) begin
          a                   = alu(op, q.sval, rd_lane(bus_rdata, q.dadr[0], bw), q.regs[SR_IDX], bw);
          next_q.regs[SR_IDX] = a.sr;
          next_q.dval         = a.res;
          next_q.st           = writes(op) ? S_DWR : S_FET;
        end
      end
      S_DWR: begin
        req.wr     = 1'b1;
        req.addr   = q.dadr;
        req.narrow = bw;
        req.wdata  = bw ? {q.dval[7:0], q.dval[7:0]} : q.dval;
        if (bus_ready) next_q.st = S_FET;
      end
      S_PUSH: begin
        req.wr    = 1'b1;
        req.addr  = q.regs[SP_IDX] - 16'h0002;
        req.wdata = q.dval;
        if (bus_ready) begin
          next_q.regs[SP_IDX] = q.regs[SP_IDX] - 16'h0002;
          if (op == OP_CALL) next_q.regs[PC_IDX] = q.sval;
          next_q.st = S_FET;
        end
      end
      S_POP1: begin
        req.rd   = 1'b1;
        req.addr = q.regs[SP_IDX];
        if (bus_ready) begin
          next_q.regs[SR_IDX] = bus_rdata;
          next_q.regs[SP_IDX] = q.regs[SP_IDX] + 16'h0002;
          next_q.st           = S_POP2;
        end
      end
      S_POP2: begin
        req.rd   = 1'b1;
        req.addr = q.regs[SP_IDX];
        if (bus_ready) begin
          next_q.regs[PC_IDX] = bus_rdata;
          next_q.regs[SP_IDX] = q.regs[SP_IDX] + 16'h0002;
          next_q.st           = S_FET;
        end
      end
      default: next_q.st = S_VEC;
    endcase
    if (go) begin
      next_q.sval = sv;
      next_q.st   = S_FET;
      if (single) begin
        case (op)
          OP_PUSH: begin
            next_q.dval = sv;
            next_q.st   = S_PUSH;
          end
          OP_CALL: begin
            next_q.dval = next_q.regs[PC_IDX];
            next_q.st   = S_PUSH;
          end
          OP_RETI: next_q.st = S_POP1;
          default: begin
            a                   = alu(op, sv, sv, q.regs[SR_IDX], bw);
            next_q.regs[SR_IDX] = a.sr;
            next_q.dval         = a.res;
            // Immediate operand has no home to write back to
            if (mem_s && !imm) next_q.st = S_DWR;
            else if (!mem_s && dreg != CG_IDX) next_q.regs[dreg] = a.res;
          end
        endcase
      end else if (i[7]) begin
        next_q.st = S_DEXT;
      end else begin
        a                   = alu(op, sv, q.regs[dreg], q.regs[SR_IDX], bw);
        next_q.regs[SR_IDX] = a.sr;
        // Status destination overrides flags; constant source ignores writes
        if (writes(op) && dreg != CG_IDX) next_q.regs[dreg] = a.res;
      end
    end
    next_q.regs[CG_IDX] = REG_RESET;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) q <= rcc_core_t'{st: S_VEC, default: '0};
    else q <= next_q;
  end
  assign bus_req     = req;
  assign pc_view     = q.regs[PC_IDX];
  assign status_view = q.regs[SR_IDX];
endmodule // rcc_core
`default_nettype wire

/* sim/rcc_core_monitor.sv */
// Port checker for the operand core
`timescale 1ns/1ps
`default_nettype none
module rcc_core_monitor (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // Bus and state view
  input wire rcc_pkg::rcc_bus_req_t bus_req,
  input wire logic [15:0]           bus_rdata,
  input wire logic                  bus_ready,
  input wire logic [15:0]           pc_view,
  input wire logic [15:0]           status_view
);
  import rcc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        fet;
  logic        regop;
  logic        branch_if_unequal;
  logic [15:0] jtgt;
  // Extension words also match; stimulus keeps them off these patterns
  assign fet = bus_req.rd && bus_ready && bus_req.addr == pc_view;
  assign regop = fet && bus_rdata[15:12] >= 4'h4 && bus_rdata[11:10] != 2'h0 && !bus_rdata[7]
                 && bus_rdata[5:4] == 2'h0 && bus_rdata[3:2] != 2'h0;
  assign branch_if_unequal = fet && bus_rdata[15:10] == 6'h08;
  assign jtgt = pc_view + 16'h2 + {{5{bus_rdata[9]}}, bus_rdata[9:0], 1'b0};
  AST_RESET_VECTOR: assert property (
    $rose(rst_n) |-> bus_req.rd && bus_req.addr == RESET_VECTOR && pc_view == PC_RESET)
    else $error("no vector fetch after reset");
  AST_HOLD_REQ: assert property (
    (bus_req.rd || bus_req.wr) && !bus_ready |=> $stable(bus_req))
    else $error("request moved while waiting");
  AST_ONE_DIR: assert property (!(bus_req.rd && bus_req.wr))
    else $error("read and write together");
  AST_REG_OP: assert property (
    regop |=> bus_req.rd && pc_view == $past(pc_view) + 16'h2 && bus_req.addr == pc_view)
    else $error("register op took more than one cycle");
  AST_CALL_PUSH: assert property (
    fet && bus_rdata[15:4] == 12'h128 |=> bus_req.wr && !bus_req.narrow && bus_req.wdata == $past(pc_view) + 16'h2)
    else $error("call did not push return address");
  AST_JMP_SELF: assert property (fet && bus_rdata == 16'h3fff |=> pc_view == $past(pc_view))
    else $error("jump to self moved");
  AST_JNE_TAKEN: assert property (branch_if_unequal && !status_view[Z_BIT] |=> pc_view == $past(jtgt))
    else $error("branch not taken with zero clear");
  AST_JNE_HELD: assert property (branch_if_unequal && status_view[Z_BIT] |=> pc_view == $past(pc_view) + 16'h2)
    else $error("branch taken with zero set");
  AST_BYTE_LANES: assert property (bus_req.wr && bus_req.narrow |-> bus_req.wdata[15:8] == bus_req.wdata[7:0])
    else $error("byte write lanes differ");
  COV_REG_OP: cover property (regop);
  COV_CALL: cover property (fet && bus_rdata[15:4] == 12'h128);
  COV_BYTE_WR: cover property (bus_req.wr && bus_req.narrow && bus_ready);
endmodule // rcc_core_monitor
bind rcc_core rcc_core_monitor i_mon (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .bus_ready(bus_ready), .pc_view(pc_view), .status_view(status_view));
`default_nettype wire

/* sim/rcc_mem.sv */
// Behavioural memory model on the shared bus
`timescale 1ns/1ps
`default_nettype none
module rcc_mem (
  // Clock and pacing
  input wire logic                  clk,
  input wire logic                  slow,
  // Shared bus
  input wire rcc_pkg::rcc_bus_req_t bus_req,
  output logic [15:0]               bus_rdata,
  output logic                      bus_ready
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  logic [1:0]  wait_cnt = 2'h0;
  logic [7:0]  idx;
  assign idx = bus_req.addr[8:1];
  // Slow pacing adds two wait states to every access
  assign bus_ready = (bus_req.rd || bus_req.wr) && (!slow || wait_cnt == 2'h2);
  // Idle data lines show the inverse of the last word, never a stale copy
  assign bus_rdata = (bus_ready && bus_req.rd) ? mem[idx] : ~last;
  always @(posedge clk) begin
    wait_cnt <= (bus_ready || !(bus_req.rd || bus_req.wr)) ? 2'h0 : wait_cnt + 2'h1;
    if (bus_ready && bus_req.rd) last <= mem[idx];
    if (bus_ready && bus_req.wr) begin
      if (!bus_req.narrow) mem[idx] <= bus_req.wdata;
      else if (bus_req.addr[0]) mem[idx][15:8] <= bus_req.wdata[15:8];
      else mem[idx][7:0] <= bus_req.wdata[7:0];
    end
  end
endmodule // rcc_mem
`default_nettype wire

/* sim/risc_cpu_operand_core_test.sv */
// Self-checking bench for the operand core
`timescale 1ns/1ps
`default_nettype none
module risc_cpu_operand_core_test;
  import rcc_pkg::*;
  typedef struct packed {
    logic [4:0]  op;
    logic        bw;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] res;
    logic        z;
  } rcc_row_t;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         slow = 1'b0;
  rcc_bus_req_t bus_req;
  logic [15:0]  bus_rdata;
  logic         bus_ready;
  logic [15:0]  pc_view;
  logic [15:0]  status_view;
  logic [15:0]  p [$];
  rcc_row_t     r;
  int           n_fail = 0;
  int           check_count = 0;
  // Op r4,r5 with r4=a, r5=b; r5 then stored at 0x0100
  rcc_row_t rows [14] = '{
    '{OP_ADD, 1'b0, 16'h0001, 16'hffff, 16'h0000, 1'b1},
    '{OP_SUB, 1'b0, 16'h0005, 16'h0005, 16'h0000, 1'b1},
    '{OP_AND, 1'b0, 16'hf0f0, 16'h0f0f, 16'h0000, 1'b1},
    '{OP_XOR, 1'b0, 16'h1234, 16'h00ff, 16'h12cb, 1'b0},
    '{OP_BIS, 1'b0, 16'h00f0, 16'h0f00, 16'h0ff0, 1'b0},
    '{OP_BIC, 1'b0, 16'h00f0, 16'h0ff0, 16'h0f00, 1'b0},
    '{OP_MOV, 1'b0, 16'habcd, 16'h0000, 16'habcd, 1'b0},
    '{OP_CMP, 1'b0, 16'h0005, 16'h0005, 16'h0005, 1'b1},
    '{OP_BIT, 1'b0, 16'h00f0, 16'h0f00, 16'h0f00, 1'b1},
    '{OP_ADDC, 1'b0, 16'h0002, 16'h0003, 16'h0005, 1'b0},
    '{OP_SUBC, 1'b0, 16'h0001, 16'h0003, 16'h0001, 1'b0},
    '{OP_ADD, 1'b1, 16'h12fe, 16'h3403, 16'h0001, 1'b0},
    '{OP_XOR, 1'b1, 16'h00ff, 16'habff, 16'h0000, 1'b1},
    '{OP_DADD, 1'b0, 16'h0002, 16'h0003, 16'h0005, 1'b0}
  };
  always #20 clk = ~clk;
  rcc_core i_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_ready(bus_ready), .pc_view(pc_view), .status_view(status_view));
  rcc_mem i_mem (.clk(clk), .slow(slow), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_ready(bus_ready));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Image loaded under reset; vector points at 0x0040
  task automatic start();
    @(negedge clk);
    rst_n = 1'b0;
    for (int i = 0; i < 256; i++) i_mem.mem[i] = 16'h0000;
    i_mem.mem[255] = 16'h0040;
    foreach (p[k]) i_mem.mem[32 + k] = p[k];
    repeat (3) @(negedge clk);
    check("reset addr", bus_req.addr, RESET_VECTOR);
    check("reset pc", pc_view, PC_RESET);
    check("reset sr", status_view, REG_RESET);
  endtask
  // Bounded wait for the store that ends a program
  task automatic go(input logic [15:0] stop);
    logic seen;
    seen  = 1'b0;
    rst_n = 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (bus_req.wr && bus_ready && bus_req.addr == stop) begin
        seen = 1'b1;
        break;
      end
    end
    check("program end", {15'h0, seen}, 16'h0001);
    repeat (3) @(negedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end
  initial begin
    foreach (rows[k]) begin
      r = rows[k];
      slow = k[0];
      p = '{16'h4034, r.a, 16'h4035, r.b, {r.op[3:0], 4'h4, 1'b0, r.bw, 6'h05},
            {8'h45, 1'b1, r.bw, 6'h02}, 16'h0100, 16'h3fff};
      start();
      go(16'h0100);
      check("result", i_mem.mem[128], r.res);
      check("zero flag", {15'h0, status_view[Z_BIT]}, {15'h0, r.z});
    end
    slow = 1'b0;
    p = {};
    for (int k = 4; k < 16; k++) p = {p, 16'(16'h4030 + k), 16'(16'h0111 * k)};
    for (int k = 4; k < 16; k++) p = {p, 16'(16'h4082 + (k << 8)), 16'(16'h00f8 + 2 * k)};
    p.push_back(16'h3fff);
    start();
    go(16'h0116);
    for (int k = 4; k < 16; k++) check("gp reg", i_mem.mem[124 + k], 16'(16'h0111 * k));
    p = '{16'h4031, 16'h0180, 16'h4038, 16'h0060, 16'h1288};
    while (p.size() < 16) p.push_back(16'h3fff);
    p = {p, 16'h4882, 16'h0100, 16'h3fff};
    slow = 1'b1;
    start();
    go(16'h0100);
    check("stacked return", i_mem.mem[191], 16'h004a);
    check("call target", i_mem.mem[128], 16'h0060);
    check("pc after call", pc_view, 16'h0064);
    p = '{16'h4036, 16'h0110, 16'h4637, 16'h4639, 16'h4034, 16'h0005, 16'h9034, 16'h0006, 16'h2002, 16'h4482,
          16'h0106, 16'h9034, 16'h0005, 16'h2002, 16'h4482, 16'h0108, 16'h4982, 16'h0104, 16'h3fff};
    start();
    i_mem.mem[136] = 16'h1111;
    i_mem.mem[137] = 16'h2222;
    go(16'h0104);
    check("second pointer word", i_mem.mem[130], 16'h2222);
    check("skipped store", i_mem.mem[131], 16'h0000);
    check("fallthrough store", i_mem.mem[132], 16'h0005);
    // Single-operand ops, indexed and indirect modes, stack return
    slow = 1'b0;
    p = '{16'h4031, 16'h0180, 16'h4035, 16'h1234, 16'h4036, 16'h0080, 16'h4037, 16'h0120, 16'h403a, 16'h0080,
          16'h403b, 16'h0005, 16'h1085, 16'h1105, 16'h1186, 16'h1006, 16'h1205, 16'h4718, 16'h0002, 16'h4729,
          16'h4887, 16'h0004, 16'h120a, 16'h120b, 16'h1300};
    while (p.size() < 32) p.push_back(16'h3fff);
    p = {p, 16'h4682, 16'h0126, 16'h4982, 16'h0128, 16'h3fff};
    start();
    i_mem.mem[144] = 16'h0c3c;
    i_mem.mem[145] = 16'h5a5a;
    go(16'h0128);
    check("swap and shift", i_mem.mem[191], 16'h1a09);
    check("indexed source", i_mem.mem[146], 16'h5a5a);
    check("extend and rotate", i_mem.mem[147], 16'hffc0);
    check("indirect source", i_mem.mem[148], 16'h0c3c);
    check("restored status", status_view, 16'h0005);
    check("pc after return", pc_view, 16'h0088);
    summarize();
  end
endmodule // risc_cpu_operand_core_test
`default_nettype wire
